// ---- verilog/cke_drive_pkg.sv ----
// Package of offsets, field layouts and reset values for the clock-enable drive register bank.
package cke_drive_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] DRIVE_STRENGTH_OFFSET = 8'h94;
  localparam logic [7:0] CAPABILITY_ID_OFFSET  = 8'ha0;

  // ==========================================================================
  // Drive strength register layout and reset value
  localparam int          ROW_COUNT        = 6;
  localparam int          SPARE_LSB        = 6;
  localparam logic [15:0] DRIVE_RESET      = 16'hffff;
  localparam logic        STRENGTH_STRONG  = 1'h0;
  localparam logic        STRENGTH_MEDIUM  = 1'h1;

  // ==========================================================================
  // Capability identifier fields
  localparam logic [7:0]  CAP_RESERVED_VAL = 8'h00;
  localparam logic [3:0]  CAP_MAJOR_REV    = 4'h2;
  localparam logic [3:0]  CAP_MINOR_REV    = 4'h0;
  localparam logic [7:0]  CAP_NEXT_PTR     = 8'h00;
  localparam logic [7:0]  CAP_ID_CODE      = 8'h02;
  localparam logic [31:0] CAP_RESET        = 32'h00200002;

  typedef struct packed {
    logic [7:0] reserved;
    logic [3:0] major_rev;
    logic [3:0] minor_rev;
    logic [7:0] next_ptr;
    logic [7:0] cap_id;
  } capability_id_t;

  typedef struct packed {
    logic [9:0] spare;
    logic [5:0] row_strength;
  } drive_strength_t;

endpackage

// ---- verilog/cke_drive_regs.sv ----
// Clock-enable drive strength and graphics port capability identifier registers.
`timescale 1ns/1ps

// Contract
// [R01] A 16-bit read/write drive strength register sits at offset 0x94 and resets to all ones.
// [R02] Bits 15 to 6 of that register are spare flops that store and return what is written.
// [R03] Bit n (0 to 5) sets the row-n clock-enable strength, 0 for 2.7x and 1 for 1.7x.
// [R04] A 32-bit read-only capability register sits at offset 0xa0 and reads 0x00200002.
// [R05] Capability bits 23 to 20 always read the major revision 0010b.
// [R06] Capability bits 19 to 16 always read zero as the minor revision.
// [R07] Capability bits 15 to 8 always read zero, ending the capability list.
// [R08] Capability bits 7 to 0 always read the capability code 0000_0010b.
// [R09] Capability bits 31 to 24 read zero and writes to that register are ignored.
module cke_drive_regs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // Per-row clock-enable strength selects, 1 selects the weaker 1.7x drive
  output logic      [5:0]  row_clock_enable_out
);

  // ==========================================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_n_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Address decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  wire hit_drive = addr_hit(reg_addr, cke_drive_pkg::DRIVE_STRENGTH_OFFSET);
  wire hit_cap   = addr_hit(reg_addr, cke_drive_pkg::CAPABILITY_ID_OFFSET);

  // ==========================================================================
  // Drive strength register
  cke_drive_pkg::drive_strength_t drive_r;
  cke_drive_pkg::drive_strength_t drive_nxt;

  assign drive_nxt = (reg_write && hit_drive) ? reg_wdata[15:0] : drive_r; // [R01] [R02]

  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      drive_r <= cke_drive_pkg::DRIVE_RESET; // [R01]
    end else begin
      drive_r <= drive_nxt;
    end
  end

  // Strength selects follow the register from flops of their own, one per row.
  logic [5:0] row_sel_r;

  genvar row;
  generate
    for (row = 0; row < cke_drive_pkg::ROW_COUNT; row = row + 1) begin : g_row
      always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
          row_sel_r[row] <= cke_drive_pkg::DRIVE_RESET[row]; // [R01]
        end else begin
          row_sel_r[row] <= drive_nxt.row_strength[row]; // [R03]
        end
      end

      AST_ROW_BIT_MATCH: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
        row_sel_r[row] == drive_r.row_strength[row])
        else $error("Row strength select differs from its register bit.");

      AST_ROW_BIT_HOLD: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
        !(reg_write && hit_drive) |=> $stable(row_sel_r[row]))
        else $error("Row strength select changed without a write.");

      AST_ROW_BIT_RESET: assert property (@(posedge clock) // [R01]
        $rose(rst_sync_n_r) |-> row_sel_r[row] == 1'b1)
        else $error("Row strength select not weak after reset.");
    end
  endgenerate

  assign row_clock_enable_out = row_sel_r;

  // ==========================================================================
  // Capability identifier, constant fields only
  cke_drive_pkg::capability_id_t cap_val;

  assign cap_val.reserved  = cke_drive_pkg::CAP_RESERVED_VAL; // [R09]
  assign cap_val.major_rev = cke_drive_pkg::CAP_MAJOR_REV;    // [R05]
  assign cap_val.minor_rev = cke_drive_pkg::CAP_MINOR_REV;    // [R06]
  assign cap_val.next_ptr  = cke_drive_pkg::CAP_NEXT_PTR;     // [R07]
  assign cap_val.cap_id    = cke_drive_pkg::CAP_ID_CODE;      // [R08]

  // ==========================================================================
  // Read path, unmapped addresses read zero
  logic [31:0] rdata_r;
  wire  [31:0] rd_sel = hit_drive ? {16'h0000, drive_r} :
                        hit_cap   ? cap_val : 32'h00000000; // [R04]
  wire  [31:0] rdata_nxt = reg_read ? rd_sel : 32'h00000000;

  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================================
  // Assertions
  AST_DRIVE_RESET: assert property (@(posedge clock) // [R01]
    $rose(rst_sync_n_r) |-> drive_r == 16'hffff)
    else $error("Drive register not all ones after reset.");

  AST_SPARE_STORE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R02]
    (reg_write && hit_drive) |=> drive_r.spare == $past(reg_wdata[15:6]))
    else $error("Spare bits did not store written value.");

  AST_ROW_FOLLOW: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
    (reg_write && hit_drive) |=> row_clock_enable_out == $past(reg_wdata[5:0]))
    else $error("Row strength outputs did not follow write.");

  AST_DRIVE_READ: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R01]
    (reg_read && hit_drive) |=> reg_rdata == {16'h0000, $past(drive_r)})
    else $error("Drive register read mismatch.");

  AST_CAP_READ: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R04]
    (reg_read && hit_cap) |=> reg_rdata == 32'h00200002)
    else $error("Capability register read mismatch.");

  AST_CAP_MAJOR: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R05]
    (reg_read && hit_cap) |=> reg_rdata[23:20] == 4'h2)
    else $error("Major revision field wrong.");

  AST_CAP_MINOR: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R06]
    (reg_read && hit_cap) |=> reg_rdata[19:16] == 4'h0)
    else $error("Minor revision field wrong.");

  AST_CAP_NEXT: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R07]
    (reg_read && hit_cap) |=> reg_rdata[15:8] == 8'h00)
    else $error("Next pointer field not zero.");

  AST_CAP_CODE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R08]
    (reg_read && hit_cap) |=> reg_rdata[7:0] == 8'h02)
    else $error("Capability code field wrong.");

  AST_CAP_WRITE_IGNORED: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R09]
    (reg_write && hit_cap) ##[1:3] (reg_read && hit_cap) |=> reg_rdata == 32'h00200002)
    else $error("Capability register changed by a write.");

  // ==========================================================================
  // Assertion helpers
  // A copy of the last drive write, kept apart so a broken write path cannot hide.
  logic [15:0] last_wr_r;

  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      last_wr_r <= cke_drive_pkg::DRIVE_RESET;
    end else if (reg_write && hit_drive) begin
      last_wr_r <= reg_wdata[15:0];
    end
  end

  // ==========================================================================
  // Reset value checks
  // These look at the first edge on which the released reset is seen high.
  AST_ROW_RESET: assert property (@(posedge clock) // [R01]
    $rose(rst_sync_n_r) |-> row_clock_enable_out == 6'h3f)
    else $error("Row strength outputs not weak after reset.");

  AST_RDATA_RESET: assert property (@(posedge clock) // [R04]
    $rose(rst_sync_n_r) |-> reg_rdata == 32'h00000000)
    else $error("Read data not zero after reset.");

  AST_SPARE_RESET: assert property (@(posedge clock) // [R02]
    $rose(rst_sync_n_r) |-> drive_r.spare == 10'h3ff)
    else $error("Spare bits not all ones after reset.");

  // ==========================================================================
  // Write path checks
  // Only a write to the drive offset may change the drive register or the pins.
  AST_DRIVE_HOLD: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R02]
    !(reg_write && hit_drive) |=> $stable(drive_r))
    else $error("Drive register changed without a write.");

  AST_CAP_WRITE_NO_DRIVE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R09]
    (reg_write && hit_cap) |=> $stable(drive_r))
    else $error("Capability write disturbed the drive register.");

  AST_UNMAPPED_WRITE_IGNORED: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R02]
    (reg_write && !hit_drive && !hit_cap) |=> $stable(drive_r))
    else $error("Unmapped write disturbed the drive register.");

  AST_ROW_STRONG: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
    (reg_write && hit_drive && reg_wdata[0] == cke_drive_pkg::STRENGTH_STRONG)
    |=> row_clock_enable_out[0] == cke_drive_pkg::STRENGTH_STRONG)
    else $error("Row zero did not select the strong drive.");

  AST_ROW_MEDIUM: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
    (reg_write && hit_drive && reg_wdata[5] == cke_drive_pkg::STRENGTH_MEDIUM)
    |=> row_clock_enable_out[5] == cke_drive_pkg::STRENGTH_MEDIUM)
    else $error("Row five did not select the medium drive.");

  AST_DRIVE_SHADOW: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R02]
    drive_r == last_wr_r)
    else $error("Drive register differs from the last write.");

  AST_ROW_SHADOW: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
    row_clock_enable_out == last_wr_r[5:0])
    else $error("Row strength outputs differ from the last write.");

  AST_WRITE_RDATA_ZERO: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R01]
    reg_write |=> reg_rdata == 32'h00000000)
    else $error("Read data not zero after a write.");

  AST_ROW_STABLE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
    !(reg_write && hit_drive) |=> $stable(row_clock_enable_out))
    else $error("Row strength outputs changed without a write.");

  AST_DRIVE_FULL_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R01]
    (reg_write && hit_drive) |=> drive_r == $past(reg_wdata[15:0]))
    else $error("Drive register did not take the whole write.");

  AST_ROW_FIELD_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R02]
    (reg_write && hit_drive) |=> drive_r.row_strength == $past(reg_wdata[5:0]))
    else $error("Row field did not take its write.");

  AST_CAP_WRITE_NO_ROW: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R09]
    (reg_write && hit_cap) |=> $stable(row_clock_enable_out))
    else $error("Capability write disturbed the row outputs.");

  // ==========================================================================
  // Read path checks
  // Read data stand for one cycle after the strobe and are zero otherwise.
  AST_RDATA_IDLE_ZERO: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R04]
    !reg_read |=> reg_rdata == 32'h00000000)
    else $error("Read data not zero without a read.");

  AST_UNMAPPED_ZERO: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R04]
    (reg_read && !hit_drive && !hit_cap) |=> reg_rdata == 32'h00000000)
    else $error("Unmapped read returned nonzero data.");

  AST_DRIVE_UPPER_ZERO: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R01]
    (reg_read && hit_drive) |=> reg_rdata[31:16] == 16'h0000)
    else $error("Drive register upper half not zero.");

  AST_SPARE_READ: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R02]
    (reg_read && hit_drive) |=> reg_rdata[15:6] == $past(last_wr_r[15:6]))
    else $error("Spare bits did not read back.");

  AST_ROW_READ: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R03]
    (reg_read && hit_drive) |=> reg_rdata[5:0] == $past(row_clock_enable_out))
    else $error("Row field read differs from the outputs.");

  AST_READ_AFTER_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R01]
    (reg_write && hit_drive) ##1 (reg_read && hit_drive)
    |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
    else $error("Back to back read missed the new value.");

  AST_RDATA_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R04]
    (reg_read && hit_cap) ##1 !reg_read |=> reg_rdata == 32'h00000000)
    else $error("Read data stood for more than one cycle.");

  AST_READ_NO_DRIVE_CHANGE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R02]
    reg_read |=> $stable(drive_r))
    else $error("A read changed the drive register.");

  AST_CAP_READ_NO_ROW: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R04]
    (reg_read && hit_cap) |=> $stable(row_clock_enable_out))
    else $error("Capability read disturbed the row outputs.");

  // ==========================================================================
  // Capability checks
  // The identifier is built from fixed fields and must match its reset value.
  AST_CAP_CONST: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R04]
    cap_val == cke_drive_pkg::CAP_RESET)
    else $error("Capability fields differ from the reset value.");

  AST_CAP_RESERVED: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R09]
    (reg_read && hit_cap) |=> reg_rdata[31:24] == 8'h00)
    else $error("Capability reserved bits not zero.");

  AST_READ_AFTER_CAP_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n_r) // [R09]
    (reg_write && hit_cap) ##1 (reg_read && hit_cap) |=> reg_rdata == cke_drive_pkg::CAP_RESET)
    else $error("Back to back capability read saw the write.");

endmodule

// ---- sim/testbench.sv ----
// Self-checking testbench for the clock-enable drive register bank.
`timescale 1ns/1ps
module testbench;
  // ==========================================================================
  // Signals
  logic        clock;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic [5:0]  row_clock_enable_out;
  int          err_count;
  int          check_count;
  int          seed;
  int          i;
  logic [31:0] rnd;
  logic [15:0] shadow;
  logic [7:0]  ua;

  cke_drive_regs i_dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .row_clock_enable_out(row_clock_enable_out));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ==========================================================================
  // Expectations and bus tasks
  function automatic logic [31:0] cap_exp();
    return {8'h00, 4'b0010, 4'b0000, 8'h00, 8'b0000_0010};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(reg_rdata, e);
  endtask

  task automatic results();
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 52;
    err_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    check({26'h0, row_clock_enable_out}, 32'h0000003f);
    rd(8'h94, 32'h0000ffff);
    rd(8'ha0, cap_exp());
    @(posedge clock);
    #1 check(reg_rdata, 32'h0);
    for (i = 0; i < 24; i++) begin
      rnd = $random(seed);
      if (i == 0) rnd = 32'h00000000;
      if (i == 1) rnd = 32'hffffffc0;
      wr(8'h94, rnd);
      shadow = rnd[15:0];
      #1 check({26'h0, row_clock_enable_out}, {26'h0, shadow[5:0]});
      rd(8'h94, {16'h0, shadow});
      wr(8'ha0, ~rnd);
      rd(8'ha0, cap_exp());
      ua = rnd[23:16];
      if (ua == 8'h94 || ua == 8'ha0) ua = ua ^ 8'h01;
      wr(ua, ~rnd);
      rd(ua, 32'h0);
      rd(8'h94, {16'h0, shadow});
    end
    results();
  end

  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
